// ==== cpmbt_pkg.sv ====
package cpmbt_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TIMING = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control word bits
  localparam int unsigned C_SLEEP_REQ = 0;
  localparam int unsigned C_SOFT_RST = 1;
  localparam int unsigned C_WAKE_FILT = 2;
  localparam int unsigned C_WAKE_IRQ_EN = 3;
  localparam int unsigned C_TLINK_EN = 4;
  localparam int unsigned C_STOP_IN_WAIT = 5;
  localparam int unsigned C_CLK_SRC = 6;
  localparam int unsigned CTRL_W = 7;
  localparam logic [6:0] CTRL_RST = 7'h02;

  // status word bits
  localparam int unsigned ST_SLEEP_ACK = 0;
  localparam int unsigned ST_SOFT = 1;
  localparam int unsigned ST_PDOWN = 2;
  localparam int unsigned ST_ON_BUS = 3;
  localparam int unsigned ST_BUS_OFF = 4;
  localparam int unsigned ST_SLP_PEND = 5;

  // timing word field positions
  localparam int unsigned T_PRESC_LSB = 0;
  localparam int unsigned T_SEG1_LSB = 8;
  localparam int unsigned T_SEG2_LSB = 12;
  localparam int unsigned T_SJW_LSB = 16;

  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned IDLE_BITS = 11;
  localparam int unsigned BUSOFF_GROUPS = 128;
  localparam int unsigned WAKE_FILT_NS = 2000;
  localparam int unsigned WAKE_FILT_CYC = (WAKE_FILT_NS * CLK_MHZ) / 1000;
  localparam logic [3:0] IDLE_LAST = 4'(IDLE_BITS - 1);
  localparam logic [7:0] BO_GRP_LAST = 8'(BUSOFF_GROUPS - 1);
  localparam logic [9:0] WAKE_FILT_LAST = 10'(WAKE_FILT_CYC - 1);

  typedef enum logic [4:0] {
    S_NORMAL = 5'h01,
    S_SLP_PEND = 5'h02,
    S_SLEEP = 5'h04,
    S_SOFT = 5'h08,
    S_PDOWN = 5'h10
  } cpmbt_mode_t;

  typedef struct packed {
    logic [5:0] presc;
    logic [3:0] seg1;
    logic [2:0] seg2;
    logic [1:0] jump_width_field;
  } cpmbt_timing_t;

  localparam cpmbt_timing_t TIMING_RST = '{presc: 6'h00, seg1: 4'h4, seg2: 3'h1, jump_width_field: 2'h0};

  // from the protocol engine
  typedef struct packed {
    logic tx_busy;
    logic rx_busy;
    logic bus_off;
    logic frame_ok;
    logic [2:0] tx_buffer_empty_flag;
    logic tx_bit;
  } cpmbt_eng_t;

  // to the protocol engine
  typedef struct packed {
    logic proto_run;
    logic defer_hold;
    logic participate;
    logic busoff_recovered;
  } cpmbt_ctl_t;
endpackage

// ==== cpmbt_sync.sv ====
`timescale 1ns/1ps
module cpmbt_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] m;
    logic [W-1:0] o;
  } cpmbt_sync_st_t;
  cpmbt_sync_st_t s_q, s_d;

  always_comb begin
    s_d.m = d;
    s_d.o = s_q.m;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= {RST, RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.o;
endmodule // cpmbt_sync

// ==== cpmbt_bit_timer.sv ====
`timescale 1ns/1ps
module cpmbt_bit_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic rx,
  input wire cpmbt_pkg::cpmbt_timing_t tm,
  output logic bit_tick,
  output logic samp_tick
);
  typedef struct packed {
    logic [5:0] pre;
    logic [5:0] q;
    logic rx_prev;
    logic tick;
    logic samp;
  } cpmbt_bt_st_t;
  cpmbt_bt_st_t s_q, s_d;
  logic [5:0] sp, blen, jump_width_field, err, jmp;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    s_d.samp = 1'b0;
    s_d.rx_prev = rx;
    sp = 6'h02 + 6'(tm.seg1);
    blen = sp + 6'h01 + 6'(tm.seg2);
    jump_width_field = 6'h01 + 6'(tm.jump_width_field);
    err = (s_q.q < sp) ? s_q.q : blen - s_q.q;
    jmp = (err < jump_width_field) ? err : jump_width_field;
    if (!run) begin
      s_d.pre = '0;
      s_d.q = '0;
    end else begin
      if (s_q.pre == tm.presc) begin
        s_d.pre = '0;
        s_d.samp = (s_q.q == sp - 6'h01);
        if (s_q.q == blen - 6'h01) begin
          s_d.q = '0;
          s_d.tick = 1'b1;
        end else begin
          s_d.q = s_q.q + 6'h01;
        end
      end else begin
        s_d.pre = s_q.pre + 6'h01;
      end
      // edge outside sync quantum: late edge stretches, early edge shortens
      if (s_q.rx_prev && !rx && s_q.q != 6'h00 && !s_d.tick) begin
        if (s_q.q < sp) begin
          s_d.q = s_d.q - jmp;
        end else if (s_d.q + jmp >= blen) begin
          s_d.q = blen - 6'h01;
        end else begin
          s_d.q = s_d.q + jmp;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '{rx_prev: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign bit_tick = s_q.tick;
  assign samp_tick = s_q.samp;
endmodule // cpmbt_bit_timer

// ==== cpmbt_top.sv ====
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module cpmbt_top #(
  parameter int unsigned INSTANCE = 0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [cpmbt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cpmbt_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_stop,
  input wire logic cpu_wait,
  input wire logic can_rx_pin,
  input wire cpmbt_pkg::cpmbt_eng_t eng,
  output cpmbt_pkg::cpmbt_ctl_t ctl,
  output logic can_tx_pin,
  output logic timer_ch4,
  output logic timer_ch5,
  output logic clock_source_select,
  output logic wakeup_irq
);
  typedef struct packed {
    cpmbt_pkg::cpmbt_mode_t mode;
    logic [cpmbt_pkg::CTRL_W-1:0] ctrl;
    cpmbt_pkg::cpmbt_timing_t tm;
    logic aw_got;
    logic w_got;
    logic [cpmbt_pkg::ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awrdy;
    logic wrdy;
    logic bvld;
    logic [1:0] bresp;
    logic arrdy;
    logic rvld;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic on_bus;
    logic [3:0] idle_cnt;
    logic [3:0] bo_bits;
    logic [7:0] bo_grp;
    logic [9:0] filt_cnt;
    logic tlink;
    logic txo;
    logic ch4;
    logic ch5;
    logic wirq;
    cpmbt_pkg::cpmbt_ctl_t ctl;
  } cpmbt_top_st_t;

  localparam cpmbt_top_st_t ST_RST = '{
    mode: cpmbt_pkg::S_SOFT,
    ctrl: cpmbt_pkg::CTRL_RST,
    tm: cpmbt_pkg::TIMING_RST,
    awrdy: 1'b1,
    wrdy: 1'b1,
    arrdy: 1'b1,
    txo: 1'b1,
    default: '0
  };

  cpmbt_top_st_t s_q, n;
  logic rx_s, bit_tick, samp_tick;
  logic pd, idle, wake, run, brec;
  logic [31:0] wmask, ctrl_w, tm_w, tm_rd, rd;
  logic [1:0] rr;

  // receive pin comes from the bus, so two flops before anything reads it
  cpmbt_sync #(.W(1), .RST(1'b1)) u_rx_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(can_rx_pin),
    .q(rx_s)
  );

  // runs only while protocol clocks run, so sleep clears the bit counter and prescaler
  cpmbt_bit_timer u_bit_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(s_q.ctl.proto_run),
    .rx(rx_s),
    .tm(s_q.tm),
    .bit_tick(bit_tick),
    .samp_tick(samp_tick)
  );

  always_comb begin
    n = s_q;
    brec = 1'b0;
    pd = cpu_stop | (cpu_wait & s_q.ctrl[cpmbt_pkg::C_STOP_IN_WAIT]);
    idle = (&eng.tx_buffer_empty_flag) & ~eng.tx_busy & ~eng.rx_busy;

    // wake detection; filter counts consecutive dominant cycles
    if (s_q.mode == cpmbt_pkg::S_SLEEP && !rx_s) begin
      if (s_q.filt_cnt != cpmbt_pkg::WAKE_FILT_LAST) begin
        n.filt_cnt = s_q.filt_cnt + 10'h001;
      end
    end else begin
      n.filt_cnt = '0;
    end
    wake = s_q.mode == cpmbt_pkg::S_SLEEP && !rx_s
      && (!s_q.ctrl[cpmbt_pkg::C_WAKE_FILT]
      || s_q.filt_cnt == cpmbt_pkg::WAKE_FILT_LAST);

    // write channel: address and data in either order, answer after both
    if (s_axi_awvalid && s_q.awrdy) begin
      n.aw_got = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wrdy) begin
      n.w_got = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (s_q.bvld && s_axi_bready) begin
      n.bvld = 1'b0;
    end
    wmask = {{8{s_q.w_strb[3]}}, {8{s_q.w_strb[2]}},
      {8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};
    tm_rd = '0;
    tm_rd[cpmbt_pkg::T_PRESC_LSB +: 6] = s_q.tm.presc;
    tm_rd[cpmbt_pkg::T_SEG1_LSB +: 4] = s_q.tm.seg1;
    tm_rd[cpmbt_pkg::T_SEG2_LSB +: 3] = s_q.tm.seg2;
    tm_rd[cpmbt_pkg::T_SJW_LSB +: 2] = s_q.tm.jump_width_field;
    ctrl_w = ({25'h0, s_q.ctrl} & ~wmask) | (s_q.w_data & wmask);
    tm_w = (tm_rd & ~wmask) | (s_q.w_data & wmask);
    if (s_q.aw_got && s_q.w_got && !s_q.bvld) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvld = 1'b1;
      n.bresp = cpmbt_pkg::RESP_OKAY;
      if (s_q.mode == cpmbt_pkg::S_PDOWN) begin
        n.bresp = cpmbt_pkg::RESP_SLVERR;
      end else if (s_q.aw_addr == cpmbt_pkg::OFS_CTRL) begin
        n.ctrl = ctrl_w[cpmbt_pkg::CTRL_W-1:0];
        // request cannot be withdrawn before sleep is reached
        if (s_q.ctrl[cpmbt_pkg::C_SLEEP_REQ] && s_q.mode != cpmbt_pkg::S_SLEEP) begin
          n.ctrl[cpmbt_pkg::C_SLEEP_REQ] = 1'b1;
        end
        // clock source only changes while stopped, avoids a glitching bit clock
        if (s_q.mode != cpmbt_pkg::S_SOFT) begin
          n.ctrl[cpmbt_pkg::C_CLK_SRC] = s_q.ctrl[cpmbt_pkg::C_CLK_SRC];
        end
      end else if (s_q.aw_addr == cpmbt_pkg::OFS_TIMING) begin
        if (s_q.mode == cpmbt_pkg::S_SOFT) begin
          n.tm.presc = tm_w[cpmbt_pkg::T_PRESC_LSB +: 6];
          n.tm.seg1 = tm_w[cpmbt_pkg::T_SEG1_LSB +: 4];
          n.tm.seg2 = tm_w[cpmbt_pkg::T_SEG2_LSB +: 3];
          n.tm.jump_width_field = tm_w[cpmbt_pkg::T_SJW_LSB +: 2];
        end
      end else if (s_q.aw_addr != cpmbt_pkg::OFS_STATUS) begin
        n.bresp = cpmbt_pkg::RESP_SLVERR;
      end
    end

    // read channel
    rd = '0;
    rr = cpmbt_pkg::RESP_OKAY;
    if (s_q.mode == cpmbt_pkg::S_PDOWN) begin
      rr = cpmbt_pkg::RESP_SLVERR;
    end else begin
      case (s_axi_araddr)
        cpmbt_pkg::OFS_CTRL: rd[cpmbt_pkg::CTRL_W-1:0] = s_q.ctrl;
        cpmbt_pkg::OFS_STATUS: begin
          rd[cpmbt_pkg::ST_SLEEP_ACK] = s_q.mode == cpmbt_pkg::S_SLEEP;
          rd[cpmbt_pkg::ST_SOFT] = s_q.mode == cpmbt_pkg::S_SOFT;
          rd[cpmbt_pkg::ST_PDOWN] = 1'b0;
          rd[cpmbt_pkg::ST_ON_BUS] = s_q.on_bus;
          rd[cpmbt_pkg::ST_BUS_OFF] = eng.bus_off;
          rd[cpmbt_pkg::ST_SLP_PEND] = s_q.mode == cpmbt_pkg::S_SLP_PEND;
        end
        cpmbt_pkg::OFS_TIMING: rd = tm_rd;
        default: rr = cpmbt_pkg::RESP_SLVERR;
      endcase
    end
    if (s_q.rvld && s_axi_rready) begin
      n.rvld = 1'b0;
    end
    if (s_axi_arvalid && s_q.arrdy) begin
      n.rvld = 1'b1;
      n.rdata = rd;
      n.rresp = rr;
    end

    // mode sequencing
    case (s_q.mode)
      cpmbt_pkg::S_NORMAL: begin
        if (s_q.ctrl[cpmbt_pkg::C_SLEEP_REQ]) begin
          n.mode = idle ? cpmbt_pkg::S_SLEEP : cpmbt_pkg::S_SLP_PEND;
        end
      end
      cpmbt_pkg::S_SLP_PEND: begin
        if (idle) begin
          n.mode = cpmbt_pkg::S_SLEEP;
        end
      end
      cpmbt_pkg::S_SLEEP: begin
        if (wake || !s_q.ctrl[cpmbt_pkg::C_SLEEP_REQ]) begin
          n.mode = cpmbt_pkg::S_NORMAL;
        end
      end
      cpmbt_pkg::S_SOFT: n.mode = cpmbt_pkg::S_NORMAL;
      cpmbt_pkg::S_PDOWN: n.mode = cpmbt_pkg::S_NORMAL;
      default: n.mode = cpmbt_pkg::S_NORMAL;
    endcase
    // bus wake drops the request, else the block would fall straight back asleep
    if (wake) begin
      n.ctrl[cpmbt_pkg::C_SLEEP_REQ] = 1'b0;
    end
    if (n.ctrl[cpmbt_pkg::C_SOFT_RST]) begin
      n.mode = cpmbt_pkg::S_SOFT;
    end
    if (pd) begin
      n.mode = cpmbt_pkg::S_PDOWN;
    end
    run = n.mode == cpmbt_pkg::S_NORMAL || n.mode == cpmbt_pkg::S_SLP_PEND;

    // rejoin the bus only after eleven recessive bits
    if (s_q.mode != cpmbt_pkg::S_NORMAL && s_q.mode != cpmbt_pkg::S_SLP_PEND) begin
      n.on_bus = 1'b0;
      n.idle_cnt = '0;
    end else if (!s_q.on_bus && samp_tick) begin
      if (!rx_s) begin
        n.idle_cnt = '0;
      end else if (s_q.idle_cnt == cpmbt_pkg::IDLE_LAST) begin
        n.on_bus = 1'b1;
        n.idle_cnt = '0;
      end else begin
        n.idle_cnt = s_q.idle_cnt + 4'h1;
      end
    end

    // bus-off recovery; ticks stop in sleep so the count just holds
    if (!eng.bus_off) begin
      n.bo_bits = '0;
      n.bo_grp = '0;
    end else if (samp_tick && s_q.ctl.proto_run) begin
      if (!rx_s) begin
        n.bo_bits = '0;
      end else if (s_q.bo_bits == cpmbt_pkg::IDLE_LAST) begin
        n.bo_bits = '0;
        if (s_q.bo_grp == cpmbt_pkg::BO_GRP_LAST) begin
          n.bo_grp = '0;
          brec = 1'b1;
        end else begin
          n.bo_grp = s_q.bo_grp + 8'h01;
        end
      end else begin
        n.bo_bits = s_q.bo_bits + 4'h1;
      end
    end

    n.ctl.proto_run = run;
    n.ctl.defer_hold = n.mode == cpmbt_pkg::S_SLEEP;
    n.ctl.participate = n.on_bus && run;
    n.ctl.busoff_recovered = brec;
    n.txo = n.ctl.participate ? eng.tx_bit : 1'b1;

    // frame pulse: assumes the engine flags end of frame on a bit boundary
    if (eng.frame_ok) begin
      n.tlink = 1'b1;
    end else if (bit_tick) begin
      n.tlink = 1'b0;
    end
    n.ch4 = n.tlink && n.ctrl[cpmbt_pkg::C_TLINK_EN] && INSTANCE == 0;
    n.ch5 = n.tlink && n.ctrl[cpmbt_pkg::C_TLINK_EN] && INSTANCE == 1;
    n.wirq = wake && s_q.ctrl[cpmbt_pkg::C_WAKE_IRQ_EN];

    n.awrdy = !n.aw_got && !n.bvld;
    n.wrdy = !n.w_got && !n.bvld;
    n.arrdy = !n.rvld;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= ST_RST;
    end else begin
      s_q <= n;
    end
  end

  assign s_axi_awready = s_q.awrdy;
  assign s_axi_wready = s_q.wrdy;
  assign s_axi_bvalid = s_q.bvld;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arrdy;
  assign s_axi_rvalid = s_q.rvld;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign ctl = s_q.ctl;
  assign can_tx_pin = s_q.txo;
  assign timer_ch4 = s_q.ch4;
  assign timer_ch5 = s_q.ch5;
  assign clock_source_select = s_q.ctrl[cpmbt_pkg::C_CLK_SRC];
  assign wakeup_irq = s_q.wirq;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_tx_quiet;
    s_q.mode inside {cpmbt_pkg::S_SLEEP, cpmbt_pkg::S_PDOWN} |-> can_tx_pin;
  endproperty
  a_tx_quiet: assert property (p_tx_quiet) else $error("tx not recessive");

  property p_sleep_entry;
    $rose(s_q.mode == cpmbt_pkg::S_SLEEP)
      |-> $past((&eng.tx_buffer_empty_flag) && !eng.tx_busy && !eng.rx_busy);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("slept while busy");

  property p_req_held;
    s_q.ctrl[cpmbt_pkg::C_SLEEP_REQ] && s_q.mode != cpmbt_pkg::S_SLEEP
      |=> s_q.ctrl[cpmbt_pkg::C_SLEEP_REQ];
  endproperty
  a_req_held: assert property (p_req_held) else $error("early request clear");

  property p_wake_clear;
    s_q.mode == cpmbt_pkg::S_SLEEP && !s_q.ctrl[cpmbt_pkg::C_SLEEP_REQ]
      |=> s_q.mode != cpmbt_pkg::S_SLEEP && !s_q.ctl.defer_hold;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("no wake on clear");

  property p_rejoin;
    $fell(s_q.mode == cpmbt_pkg::S_SLEEP) |-> !s_q.on_bus ##1 !ctl.participate;
  endproperty
  a_rejoin: assert property (p_rejoin) else $error("joined bus too early");

  property p_bo_pause;
    s_q.mode == cpmbt_pkg::S_SLEEP && eng.bus_off |=> $stable(s_q.bo_grp) && $stable(s_q.bo_bits);
  endproperty
  a_bo_pause: assert property (p_bo_pause) else $error("recovery ran asleep");

  property p_pdown;
    cpu_stop || (cpu_wait && s_q.ctrl[cpmbt_pkg::C_STOP_IN_WAIT])
      |=> s_q.mode == cpmbt_pkg::S_PDOWN && !ctl.proto_run;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power-down missed");

  property p_pd_refuse;
    s_q.mode == cpmbt_pkg::S_PDOWN && s_q.aw_got && s_q.w_got && !s_q.bvld
      |=> s_axi_bvalid && s_axi_bresp == cpmbt_pkg::RESP_SLVERR;
  endproperty
  a_pd_refuse: assert property (p_pd_refuse) else $error("access in power-down");

  property p_soft;
    s_q.ctrl[cpmbt_pkg::C_SOFT_RST]
      |-> s_q.mode inside {cpmbt_pkg::S_SOFT, cpmbt_pkg::S_PDOWN} && !ctl.proto_run;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset not stopped");

  property p_tlink;
    $rose(s_q.tlink) |-> $past(eng.frame_ok);
  endproperty
  a_tlink: assert property (p_tlink) else $error("stray frame pulse");

  property p_wirq;
    wakeup_irq |-> $past(s_q.mode == cpmbt_pkg::S_SLEEP && s_q.ctrl[cpmbt_pkg::C_WAKE_IRQ_EN]);
  endproperty
  a_wirq: assert property (p_wirq) else $error("wake irq not gated");
endmodule // cpmbt_top

// ==== cpmbt_bus_model.sv ====
`timescale 1ns/1ps
module cpmbt_bus_model (
  input wire logic aclk,
  input wire logic dominant,
  input wire logic frame,
  input wire logic [2:0] tx_buffer_empty_flag,
  input wire logic tx_busy,
  input wire logic rx_busy,
  input wire logic bus_off,
  output logic can_rx_pin,
  output cpmbt_pkg::cpmbt_eng_t eng
);
  logic frame_q = 1'b0;
  logic tog_q = 1'b0;
  // bus recessive between frames; engine bit keeps moving so a stuck pin shows
  assign can_rx_pin = ~dominant;
  always @(posedge aclk) begin
    frame_q <= frame;
    tog_q <= ~tog_q;
  end
  assign eng = '{tx_busy: tx_busy, rx_busy: rx_busy, bus_off: bus_off,
    frame_ok: frame & ~frame_q, tx_buffer_empty_flag: tx_buffer_empty_flag, tx_bit: tog_q};
endmodule // cpmbt_bus_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic cpu_stop = 1'b0;
  logic cpu_wait = 1'b0;
  logic dominant = 1'b0;
  logic frame = 1'b0;
  logic [2:0] tx_buffer_empty_flag = 3'h7;
  logic tx_busy = 1'b0;
  logic rx_busy = 1'b0;
  logic bus_off = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rx_pin, tx_pin, ch4, ch5, csel, wirq;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd, v;
  cpmbt_pkg::cpmbt_eng_t eng;
  cpmbt_pkg::cpmbt_ctl_t ctl;
  int n_fail = 0;
  int checked = 0;
  int seed = 3145;
  int k;

  always #2 aclk = ~aclk;

  cpmbt_bus_model bus_u (.aclk(aclk), .dominant(dominant), .frame(frame), .tx_buffer_empty_flag(tx_buffer_empty_flag),
    .tx_busy(tx_busy), .rx_busy(rx_busy), .bus_off(bus_off), .can_rx_pin(rx_pin), .eng(eng));

  cpmbt_top #(.INSTANCE(0)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cpu_stop(cpu_stop), .cpu_wait(cpu_wait), .can_rx_pin(rx_pin), .eng(eng), .ctl(ctl),
    .can_tx_pin(tx_pin), .timer_ch4(ch4), .timer_ch5(ch5), .clock_source_select(csel),
    .wakeup_irq(wirq));

  task final_report;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task tmo;
    n_fail++;
    final_report();
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rsp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (i == 50) tmo();
  endtask

  task rd_t(input logic [7:0] a);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (i == 50) tmo();
  endtask

  // software side of the handshake: poll the status word
  task poll(input int b, input logic x);
    int i;
    for (i = 0; i < 40; i++) begin
      rd_t(cpmbt_pkg::OFS_STATUS);
      if (rd[b] === x) break;
    end
    chk("status bit", 32'(rd[b]), 32'(x));
  endtask

  function logic sig(input int w);
    case (w)
      0: return wirq;
      1: return ctl.participate;
      2: return ch4;
      3: return ~ch4;
      default: return ctl.busoff_recovered;
    endcase
  endfunction

  task wt(input int w, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge aclk);
      if (sig(w) === 1'b1) break;
    end
    checked++;
    if (i == lim) tmo();
  endtask

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd_t(cpmbt_pkg::OFS_CTRL);
    chk("ctrl", rd, 32'(cpmbt_pkg::CTRL_RST));
    rd_t(cpmbt_pkg::OFS_TIMING);
    chk("timing", rd, 32'h0000_1400);
    rd_t(8'h0c);
    chk("unmapped resp", 32'(rsp), 32'(cpmbt_pkg::RESP_SLVERR));
    for (k = 0; k < 6; k++) begin
      v = $random(seed) & 32'h0003_7f3f;
      wr(cpmbt_pkg::OFS_TIMING, v);
      rd_t(cpmbt_pkg::OFS_TIMING);
      chk("timing", rd, v);
    end
    wr(cpmbt_pkg::OFS_TIMING, 32'h0000_1400);
    wr(cpmbt_pkg::OFS_CTRL, 32'h42);
    chk("clk sel", 32'(csel), 32'h1);
    wr(cpmbt_pkg::OFS_CTRL, 32'h40);
    // sleep asked while a transmit is still scheduled
    tx_buffer_empty_flag <= 3'h6;
    tx_busy <= 1'b1;
    wr(cpmbt_pkg::OFS_CTRL, 32'h41);
    rd_t(cpmbt_pkg::OFS_STATUS);
    chk("pend ack", 32'(rd[5:0] & 6'h21), 32'h20);
    wr(cpmbt_pkg::OFS_CTRL, 32'h40);
    rd_t(cpmbt_pkg::OFS_CTRL);
    chk("req kept", 32'(rd[0]), 32'h1);
    tx_buffer_empty_flag <= 3'h7;
    tx_busy <= 1'b0;
    poll(0, 1'b1);
    chk("tx pin", 32'(tx_pin), 32'h1);
    chk("proto run", 32'(ctl.proto_run), 32'h0);
    chk("defer", 32'(ctl.defer_hold), 32'h1);
    wr(cpmbt_pkg::OFS_CTRL, 32'h40);
    poll(0, 1'b0);
    chk("defer", 32'(ctl.defer_hold), 32'h0);
    chk("join", 32'(ctl.participate), 32'h0);
    wt(1, 400);
    // once on the bus the pin follows the engine, which toggles every cycle
    v[0] = tx_pin;
    @(posedge aclk);
    chk("tx follows", 32'(tx_pin), 32'(!v[0]));
    // sleep during reception, filtered wake with irq enabled; bus-off count pauses
    bus_off <= 1'b1;
    rx_busy <= 1'b1;
    wr(cpmbt_pkg::OFS_CTRL, 32'h4d);
    rd_t(cpmbt_pkg::OFS_STATUS);
    chk("ack", 32'(rd[0]), 32'h0);
    chk("bus off", 32'(rd[4]), 32'h1);
    rx_busy <= 1'b0;
    poll(0, 1'b1);
    @(posedge aclk);
    dominant <= 1'b1;
    repeat (100) @(posedge aclk);
    dominant <= 1'b0;
    poll(0, 1'b1);
    @(posedge aclk);
    dominant <= 1'b1;
    wt(0, 700);
    dominant <= 1'b0;
    rd_t(cpmbt_pkg::OFS_CTRL);
    chk("req", 32'(rd[0]), 32'h0);
    poll(0, 1'b0);
    wt(4, 12500);
    bus_off <= 1'b0;
    // frame pulse routed to the timer
    wr(cpmbt_pkg::OFS_CTRL, 32'h50);
    frame <= 1'b1;
    @(posedge aclk);
    frame <= 1'b0;
    wt(2, 10);
    chk("ch5", 32'(ch5), 32'h0);
    wt(3, 40);
    // idle the controller through sleep before soft reset
    wr(cpmbt_pkg::OFS_CTRL, 32'h41);
    poll(0, 1'b1);
    wr(cpmbt_pkg::OFS_CTRL, 32'h42);
    rd_t(cpmbt_pkg::OFS_STATUS);
    chk("soft wake", 32'(rd[1:0]), 32'h2);
    wr(cpmbt_pkg::OFS_CTRL, 32'h40);
    tx_busy <= 1'b1;
    wr(cpmbt_pkg::OFS_CTRL, 32'h42);
    chk("proto run", 32'(ctl.proto_run), 32'h0);
    tx_busy <= 1'b0;
    wr(cpmbt_pkg::OFS_CTRL, 32'h60);
    @(posedge aclk);
    cpu_stop <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("tx pin", 32'(tx_pin), 32'h1);
    chk("join", 32'(ctl.participate), 32'h0);
    rd_t(cpmbt_pkg::OFS_CTRL);
    chk("pd resp", {rd[29:0], rsp}, 32'(cpmbt_pkg::RESP_SLVERR));
    cpu_stop <= 1'b0;
    cpu_wait <= 1'b1;
    repeat (2) @(posedge aclk);
    rd_t(cpmbt_pkg::OFS_CTRL);
    chk("wait resp", 32'(rsp), 32'(cpmbt_pkg::RESP_SLVERR));
    cpu_wait <= 1'b0;
    repeat (2) @(posedge aclk);
    rd_t(cpmbt_pkg::OFS_CTRL);
    chk("run resp", 32'(rsp), 32'(cpmbt_pkg::RESP_OKAY));
    final_report();
  end
endmodule // tb_top
